// ===== hdl/pbrpc_top.sv
// Purpose: push-button decode, reset output and power-mode control
// Assumes: pins are asynchronous; strong press seen on its own detector pin
// Notes: regulator enables are digital requests only
// Function
// - weak press held 32 ms powers on
// - weak press held 10 s forces shutdown
// - strong press is a timed manual reset
// - short manual reset pulls reset at once
// - soft reset sets flag, read clears it
// - long manual reset cycles all regulators
// - power cycle sets flag, read clears it
// - button-state output follows the button input
// - startup holds reset until time-out elapses
// - interrupt pin low while unmasked source pends
// - interrupt sources masked after reset, writable
// - all three pins only pull low
// - hold and enable high keep all on
// - both low leaves only always-on, battery permitting
// - armed shutdown bit or hold low powers off
// - button or enable wakes core from sleep
`timescale 1ns/1ps
module pbrpc_top #(
    parameter int MS_CYCLES = pbrpc_pkg::MS_CYCLES_DEF,
    parameter logic [pbrpc_pkg::TMR_W-1:0] RESET_TIMEOUT_MS = pbrpc_pkg::RESET_TIMEOUT_MS_DEF,
    parameter bit MR_LONG_VARIANT = 1'b0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // push button and processor pins
    input wire logic push_button_in_n,
    input wire logic pushButtonStrongN,
    input wire logic power_hold_in,
    input wire logic power_enable_in,
    input wire logic batteryOk,
    // open-drain pins
    output logic system_reset_out_n,
    output logic systemResetOe,
    output logic button_state_out_n,
    output logic buttonStateOe,
    output logic interrupt_out_n,
    output logic interruptOe,
    // regulator enables
    output logic alwaysOnEn,
    output logic coreEn,
    output logic mainEn,
    // register port
    input wire logic [pbrpc_pkg::ADDR_W-1:0] regAddr,
    input wire logic [pbrpc_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [pbrpc_pkg::DATA_W-1:0] regRdData
);
    import pbrpc_pkg::*;

    localparam logic [TMR_W-1:0] MR_THRESH_MS = MR_LONG_VARIANT ? MR_LONG_MS : MR_SHORT_MS;
    localparam int DIV_W = $clog2(MS_CYCLES);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);

    function automatic logic isPowered(input pbrpc_state_t s);
        isPowered = (s == PS_ON) || (s == PS_SLEEP);
    endfunction

    // synchronised pins
    logic [SYNC_W-1:0] pinSync;
    logic btnLow, strongLow, holdIn, enIn, batOk;
    pbrpc_sync #(
        .WIDTH(SYNC_W),
        .IDLE(5'h03)
    ) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .asyncIn({batteryOk, power_enable_in, power_hold_in, pushButtonStrongN,
            push_button_in_n}),
        .syncOut(pinSync)
    );
    assign btnLow = !pinSync[0];
    assign strongLow = !pinSync[1];
    assign holdIn = pinSync[2];
    assign enIn = pinSync[3];
    assign batOk = pinSync[4];

    // millisecond tick
    logic [DIV_W-1:0] div_q, div_d;
    logic msTick_q;
    logic divWrap;
    assign divWrap = (div_q == DIV_LAST);
    assign div_d = divWrap ? '0 : div_q + 1'b1;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            div_q <= '0;
            msTick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            msTick_q <= divWrap;
        end
    end

    // state and helpers
    pbrpc_state_t state_q, state_d;
    logic strongSeen_q, strongSeen_d;
    logic btnLowPrev_q;
    logic holdSeen_q, holdSeen_d;
    logic rstActive_q, rstActive_d;
    logic srFlag_q, srFlag_d, pcFlag_q, pcFlag_d;
    logic armBit_q, watchdog_soft_reset_enable_q;
    logic [IRQ_W-1:0] mask_q;
    logic [TMR_W-1:0] pressCnt, rstCnt;
    logic mrHeld, btnRelease, rstStart, weakHeld;
    logic softEvent, longEvent, forceOff, powerOnEvent;
    logic shutdownReq, cycleDone, statusRead;
    logic wrCtl, wrMask;
    logic [IRQ_W-1:0] pending;
    logic [DATA_W-1:0] rdMux;

    // press duration, restarts with every press
    pbrpc_ms_timer u_press (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick(msTick_q),
        .run(btnLow),
        .clear(!btnLow),
        .count_q(pressCnt)
    );

    // reset time-out and power-cycle off time
    pbrpc_ms_timer u_rst (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick(msTick_q),
        .run(1'b1),
        .clear(mrHeld || rstStart),
        .count_q(rstCnt)
    );

    // press classification
    assign strongSeen_d = btnLow && (strongSeen_q || strongLow);
    assign mrHeld = btnLow && (strongSeen_q || strongLow);
    assign weakHeld = btnLow && !strongSeen_q && !strongLow;
    assign btnRelease = btnLowPrev_q && !btnLow;
    // a press already past the forced-off time must not power straight back on
    assign powerOnEvent = (state_q == PS_OFF) && weakHeld && (pressCnt >= PWRON_MS)
        && (pressCnt < FORCE_OFF_MS);
    assign forceOff = (state_q != PS_OFF) && weakHeld && (pressCnt >= FORCE_OFF_MS);
    assign softEvent = isPowered(state_q) && btnRelease && strongSeen_q
        && (pressCnt < MR_THRESH_MS);
    assign longEvent = isPowered(state_q) && mrHeld && (pressCnt >= MR_THRESH_MS);
    assign cycleDone = (state_q == PS_CYCLE) && !btnLow && (rstCnt >= CYCLE_OFF_MS);

    // register decode
    assign wrCtl = regWr && (regAddr == ADDR_CONTROL);
    assign wrMask = regWr && (regAddr == ADDR_MASK);
    assign statusRead = regRd && (regAddr == ADDR_STATUS);
    // shutdown only counts when the arm bit was already set
    assign shutdownReq = wrCtl && regWrData[CTL_OFF_BIT] && armBit_q;

    // power-mode sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            PS_OFF: begin
                if (powerOnEvent) begin
                    state_d = PS_BOOT;
                end
            end
            PS_BOOT: begin
                // abort unless the processor took hold before release
                if (forceOff) begin
                    state_d = PS_OFF;
                end else if (!btnLow) begin
                    state_d = holdIn ? PS_ON : PS_OFF;
                end
            end
            PS_ON: begin
                if (forceOff || shutdownReq) begin
                    state_d = PS_OFF;
                end else if (longEvent) begin
                    state_d = PS_CYCLE;
                end else if (holdSeen_q && !holdIn) begin
                    state_d = PS_OFF;
                end else if (holdIn && !enIn && !btnLow) begin
                    // a held button keeps the core awake, else the core enable chatters
                    state_d = PS_SLEEP;
                end
            end
            PS_SLEEP: begin
                if (forceOff || shutdownReq || !holdIn) begin
                    state_d = PS_OFF;
                end else if (longEvent) begin
                    state_d = PS_CYCLE;
                end else if (btnLow || enIn) begin
                    state_d = PS_ON;
                end
            end
            PS_CYCLE: begin
                if (forceOff) begin
                    state_d = PS_OFF;
                end else if (cycleDone) begin
                    state_d = PS_ON;
                end
            end
            default: begin
                state_d = PS_OFF;
            end
        endcase
    end

    // hold is only trusted once the processor has shown it
    assign holdSeen_d = (state_d == PS_CYCLE || state_d == PS_OFF) ? 1'b0
        : (holdSeen_q || holdIn);

    // reset output: startup, manual press, and after a cycle
    assign rstStart = ((state_q != PS_BOOT) && (state_d == PS_BOOT)) || cycleDone;
    always_comb begin
        rstActive_d = rstActive_q;
        if (mrHeld && isPowered(state_q)) begin
            rstActive_d = 1'b1;
        end else if (rstStart || (state_q == PS_CYCLE)) begin
            rstActive_d = 1'b1;
        end else if (rstActive_q && !mrHeld && (rstCnt >= RESET_TIMEOUT_MS)) begin
            rstActive_d = 1'b0;
        end
    end

    // sticky flags, a new event beats a same-cycle read clear
    assign srFlag_d = softEvent || (srFlag_q && !statusRead);
    assign pcFlag_d = cycleDone || (pcFlag_q && !statusRead);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= PS_OFF;
            strongSeen_q <= 1'b0;
            btnLowPrev_q <= 1'b0;
            holdSeen_q <= 1'b0;
            rstActive_q <= 1'b1;
            srFlag_q <= 1'b0;
            pcFlag_q <= 1'b0;
        end else begin
            state_q <= state_d;
            strongSeen_q <= strongSeen_d;
            btnLowPrev_q <= btnLow;
            holdSeen_q <= holdSeen_d;
            rstActive_q <= rstActive_d;
            srFlag_q <= srFlag_d;
            pcFlag_q <= pcFlag_d;
        end
    end

    // control and mask registers
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            armBit_q <= 1'b0;
            watchdog_soft_reset_enable_q <= 1'b0;
            mask_q <= MASK_RST;
        end else begin
            if (wrCtl) begin
                armBit_q <= regWrData[CTL_ARM_BIT] && !shutdownReq;
                watchdog_soft_reset_enable_q <= regWrData[CTL_WDSR_BIT];
            end
            if (wrMask) begin
                mask_q <= regWrData[IRQ_W-1:0];
            end
        end
    end

    // interrupt sources; a 1 in the mask enables a source
    assign pending = {btnLow, !batOk, pcFlag_q, srFlag_q} & mask_q;

    // read mux, data appear the cycle after the strobe
    always_comb begin
        rdMux = '0;
        case (regAddr)
            ADDR_STATUS: begin
                rdMux[ST_SR_BIT] = srFlag_q;
                rdMux[ST_PC_BIT] = pcFlag_q;
            end
            ADDR_CONTROL: begin
                rdMux[CTL_ARM_BIT] = armBit_q;
                rdMux[CTL_WDSR_BIT] = watchdog_soft_reset_enable_q;
            end
            ADDR_MASK: begin
                rdMux[IRQ_W-1:0] = mask_q;
            end
            ADDR_STATE: begin
                rdMux = {coreEn, mainEn, alwaysOnEn, rstActive_q, 1'b0, state_q};
            end
            default: begin
                rdMux = '0;
            end
        endcase
    end

    // registered pins; open-drain data is a constant low
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData <= '0;
            system_reset_out_n <= 1'b0;
            button_state_out_n <= 1'b0;
            interrupt_out_n <= 1'b0;
            systemResetOe <= 1'b1;
            buttonStateOe <= 1'b0;
            interruptOe <= 1'b0;
            alwaysOnEn <= 1'b0;
            coreEn <= 1'b0;
            mainEn <= 1'b0;
        end else begin
            regRdData <= regRd ? rdMux : '0;
            system_reset_out_n <= 1'b0;
            button_state_out_n <= 1'b0;
            interrupt_out_n <= 1'b0;
            systemResetOe <= rstActive_q;
            buttonStateOe <= btnLow;
            interruptOe <= |pending;
            alwaysOnEn <= (state_q == PS_CYCLE) ? 1'b0
                : (state_q == PS_OFF) ? batOk : 1'b1;
            coreEn <= (state_q == PS_ON) || (state_q == PS_BOOT);
            mainEn <= (state_q != PS_OFF) && (state_q != PS_CYCLE);
        end
    end

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    AST_PWRON: assert property (
        (state_q == PS_OFF) ##1 (state_q == PS_BOOT) |-> $past(pressCnt) >= PWRON_MS
    ) else $error("power-on without a 32 ms press");

    AST_FORCE_OFF: assert property (
        forceOff |=> (state_q == PS_OFF) ##1 !mainEn && !coreEn
    ) else $error("forced shutdown did not power off");

    AST_MR_RESET: assert property (
        (mrHeld && isPowered(state_q)) |=> rstActive_q ##1 systemResetOe
    ) else $error("manual reset did not pull reset low");

    AST_RESET_HOLD: assert property (
        (rstActive_q && mrHeld) |=> rstActive_q
    ) else $error("reset released while manual reset held");

    AST_SR_FLAG: assert property (
        softEvent |=> srFlag_q && (state_q == $past(state_q))
    ) else $error("soft reset flag not set");

    AST_CYCLE: assert property (
        (longEvent && (state_q == PS_ON) && !forceOff && !shutdownReq) |=> (state_q == PS_CYCLE)
            ##1 (!mainEn && !coreEn && !alwaysOnEn)
    ) else $error("long press did not cycle regulators");

    AST_PC_FLAG: assert property (
        cycleDone |=> pcFlag_q && (state_q == PS_ON)
    ) else $error("power cycle flag not set");

    AST_CLEAR_ON_READ: assert property (
        (statusRead && !softEvent && srFlag_q) |=> !srFlag_q
    ) else $error("status read did not clear flag");

    AST_BTN_STATE: assert property (
        ##1 (buttonStateOe == $past(btnLow))
    ) else $error("button state output does not follow button");

    AST_IRQ: assert property (
        (|({btnLow, !batOk, pcFlag_q, srFlag_q} & mask_q)) |=> interruptOe
    ) else $error("unmasked interrupt not signalled");

    AST_OPEN_DRAIN: assert property (
        !system_reset_out_n && !button_state_out_n && !interrupt_out_n
    ) else $error("open-drain pin driven high");

    AST_ALL_ON: assert property (
        (state_q == PS_ON) ##1 (state_q == PS_ON) |-> mainEn && coreEn && alwaysOnEn
    ) else $error("regulators off while fully on");

    AST_OFF_AO: assert property (
        (state_q == PS_OFF) [*2] |-> !mainEn && !coreEn && (alwaysOnEn == $past(batOk))
    ) else $error("off state regulator enables wrong");

    AST_WAKE: assert property (
        ((state_q == PS_SLEEP) && holdIn && !forceOff && !shutdownReq && !longEvent
            && (btnLow || enIn)) |=> (state_q == PS_ON) ##1 coreEn
    ) else $error("sleep wake did not enable core");

    COV_BOOT: cover property ((state_q == PS_BOOT) ##1 (state_q == PS_ON));
    COV_SOFT: cover property (softEvent);
    COV_CYCLE: cover property (cycleDone);
    COV_SLEEP_WAKE: cover property ((state_q == PS_SLEEP) ##1 (state_q == PS_ON));
endmodule // pbrpc_top

// ===== hdl/pbrpc_pkg.sv
// Purpose: shared constants and types for the push-button reset and power control
// Assumes: 50 MHz system clock, 8-bit register port
// Notes: millisecond figures are counted on a one-cycle tick
package pbrpc_pkg;
    // clock and time base
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
    // press and sequence durations in milliseconds
    localparam int TMR_W = 14;
    localparam logic [TMR_W-1:0] PWRON_MS = 14'h0020;
    localparam logic [TMR_W-1:0] FORCE_OFF_MS = 14'h2710;
    localparam logic [TMR_W-1:0] MR_SHORT_MS = 14'h0FA0;
    localparam logic [TMR_W-1:0] MR_LONG_MS = 14'h2710;
    localparam logic [TMR_W-1:0] RESET_TIMEOUT_MS_DEF = 14'h0014;
    localparam logic [TMR_W-1:0] CYCLE_OFF_MS = 14'h0040;
    // register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_STATE = 4'h3;
    // status bits
    localparam int ST_SR_BIT = 0;
    localparam int ST_PC_BIT = 1;
    // control bits
    localparam int CTL_ARM_BIT = 0;
    localparam int CTL_OFF_BIT = 1;
    localparam int CTL_WDSR_BIT = 2;
    // interrupt source bits, shared by mask and pending
    localparam int IRQ_W = 4;
    localparam int IRQ_SR_BIT = 0;
    localparam int IRQ_PC_BIT = 1;
    localparam int IRQ_BAT_BIT = 2;
    localparam int IRQ_BTN_BIT = 3;
    localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;
    // synchronised input lanes
    localparam int SYNC_W = 5;
    // power states, gray along off, boot, on, sleep
    typedef enum logic [2:0] {
        PS_OFF = 3'b000,
        PS_BOOT = 3'b001,
        PS_ON = 3'b011,
        PS_SLEEP = 3'b010,
        PS_CYCLE = 3'b111
    } pbrpc_state_t;
endpackage

// ===== hdl/pbrpc_sync.sv
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: inputs are static levels, no pulses shorter than a clock
// Notes: reset value set per lane to the idle level of each pin
`timescale 1ns/1ps
module pbrpc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] IDLE = '0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // levels
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;

    // first stage is read only by the second
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= IDLE;
            syncOut <= IDLE;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule // pbrpc_sync

// ===== hdl/pbrpc_ms_timer.sv
// Purpose: saturating millisecond counter
// Assumes: tick is a one-cycle enable from the millisecond divider
// Notes: clear wins over count
`timescale 1ns/1ps
module pbrpc_ms_timer (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // control
    input wire logic tick,
    input wire logic run,
    input wire logic clear,
    // count
    output logic [pbrpc_pkg::TMR_W-1:0] count_q
);
    import pbrpc_pkg::*;

    logic [TMR_W-1:0] count_d;
    logic atMax;

    assign atMax = &count_q;
    assign count_d = clear ? '0 : (run && tick && !atMax) ? count_q + 1'b1 : count_q;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end
endmodule // pbrpc_ms_timer

// ===== testbench/pbrpc_host_model.sv
// Purpose: host processor pins facing the power controller
// Assumes: host is powered while mainEn is high
// Notes: an unpowered host leaves its pins at the pull-down level
`timescale 1ns/1ps
module pbrpc_host_model (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // host side
    input wire logic mainEn,
    input wire logic holdReq,
    input wire logic enReq,
    input wire logic [7:0] holdDelay,
    // pins
    output logic power_hold_in,
    output logic power_enable_in
);
    logic [7:0] bootWait_q;
    // boot time of the host, prompt or slow
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bootWait_q <= 8'h00;
        end else if (!mainEn) begin
            bootWait_q <= 8'h00;
        end else if (bootWait_q != holdDelay) begin
            bootWait_q <= bootWait_q + 8'h01;
        end
    end
    // hold taken only once booted; dropping holdReq is a software shutdown
    assign power_hold_in = mainEn && holdReq && (bootWait_q == holdDelay);
    assign power_enable_in = mainEn && enReq;
endmodule // pbrpc_host_model

// ===== testbench/pbrpc_top_tb.sv
// Purpose: self-checking bench for the push-button power control
// Assumes: short millisecond tick so second-long presses stay cheap
// Notes: pins are resolved with pull-ups before checking
`timescale 1ns/1ps
module pbrpc_top_tb;
    import pbrpc_pkg::*;
    localparam int MSC = 2;
    logic mclk, sys_rst, push_button_in_n, pushButtonStrongN, power_hold_in, power_enable_in;
    logic batteryOk, system_reset_out_n, systemResetOe, button_state_out_n, buttonStateOe;
    logic interrupt_out_n, interruptOe, alwaysOnEn, coreEn, mainEn, regWr, regRd, holdReq, enReq;
    logic resetWire, btnWire, irqWire;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData, regRdData, rd;
    logic [7:0] holdDelay;
    int fails, samples_checked;
    int durMs[3] = '{10, 3900, 4100};
    logic [7:0] flagExp[3] = '{8'h01, 8'h01, 8'h02};
    // pull-ups on the three open-drain pins
    assign resetWire = systemResetOe ? system_reset_out_n : 1'b1;
    assign btnWire = buttonStateOe ? button_state_out_n : 1'b1;
    assign irqWire = interruptOe ? interrupt_out_n : 1'b1;
    pbrpc_top #(.MS_CYCLES(MSC), .RESET_TIMEOUT_MS(RESET_TIMEOUT_MS_DEF),
        .MR_LONG_VARIANT(1'b0)) u_dut (
        .mclk(mclk), .sys_rst(sys_rst), .push_button_in_n(push_button_in_n),
        .pushButtonStrongN(pushButtonStrongN), .power_hold_in(power_hold_in),
        .power_enable_in(power_enable_in), .batteryOk(batteryOk),
        .system_reset_out_n(system_reset_out_n), .systemResetOe(systemResetOe),
        .button_state_out_n(button_state_out_n), .buttonStateOe(buttonStateOe),
        .interrupt_out_n(interrupt_out_n), .interruptOe(interruptOe),
        .alwaysOnEn(alwaysOnEn), .coreEn(coreEn), .mainEn(mainEn), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
    pbrpc_host_model u_host (.mclk(mclk), .sys_rst(sys_rst), .mainEn(mainEn),
        .holdReq(holdReq), .enReq(enReq), .holdDelay(holdDelay),
        .power_hold_in(power_hold_in), .power_enable_in(power_enable_in));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rdReg(input logic [3:0] a);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        rd = regRdData;
    endtask
    task automatic waitState(input logic [2:0] s, input int lim);
        int i;
        i = 0;
        do begin
            rdReg(ADDR_STATE);
            i++;
        end while (rd[2:0] !== s && i < lim);
        check({5'h00, rd[2:0]}, {5'h00, s});
        if (rd[2:0] !== s) stop_test();
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return resetWire;
            1: return coreEn;
            default: return irqWire;
        endcase
    endfunction
    task automatic waitSig(input int s, input logic v, input int lim, output int n);
        n = 0;
        while (pick(s) !== v && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check({7'h00, pick(s)}, {7'h00, v});
        if (pick(s) !== v) stop_test();
    endtask
    task automatic pins(input logic pb, input logic st);
        @(posedge mclk);
        push_button_in_n <= pb;
        pushButtonStrongN <= st;
    endtask
    task automatic powerOn(input logic [7:0] d, input int ms);
        holdReq <= 1'b1;
        holdDelay <= d;
        pins(1'b0, 1'b1);
        cyc(ms * MSC);
        pins(1'b1, 1'b1);
        waitState(PS_ON, 50);
    endtask
    initial begin
        int n;
        sys_rst = 1'b1;
        {push_button_in_n, pushButtonStrongN, batteryOk, enReq} = 4'hF;
        {regWr, regRd, holdReq} = 3'h0;
        regAddr = 4'h0;
        regWrData = 8'h00;
        holdDelay = 8'h0A;
        fails = 0;
        samples_checked = 0;
        cyc(20);
        sys_rst <= 1'b0;
        waitSig(0, 1'b1, 300, n);
        check({7'h00, n >= 38 && n <= 46}, 8'h01);
        rdReg(ADDR_MASK);
        check(rd, 8'h00);
        rdReg(4'hF);
        check(rd, 8'h00);
        // boot abort: host never takes hold
        pins(1'b0, 1'b1);
        cyc(28 * MSC);
        rdReg(ADDR_STATE);
        check({5'h00, rd[2:0]}, {5'h00, PS_OFF});
        cyc(20 * MSC);
        check({7'h00, btnWire}, 8'h00);
        rdReg(ADDR_STATE);
        check({5'h00, rd[2:0]}, {5'h00, PS_BOOT});
        pins(1'b1, 1'b1);
        waitState(PS_OFF, 50);
        check({7'h00, mainEn}, 8'h00);
        check({7'h00, btnWire}, 8'h01);
        powerOn(8'h0A, 50);
        check({5'h00, coreEn, mainEn, alwaysOnEn}, 8'h07);
        waitSig(0, 1'b1, 300, n);
        wr(ADDR_MASK, 8'h03);
        wr(4'hF, 8'hFF);
        rdReg(ADDR_MASK);
        check(rd, 8'h03);
        // short, near-threshold and long manual resets
        for (int k = 0; k < 3; k++) begin
            pins(1'b0, 1'b0);
            waitSig(0, 1'b0, 6, n);
            cyc(durMs[k] * MSC);
            if (k == 2) begin
                waitState(PS_CYCLE, 5);
                check({5'h00, coreEn, mainEn, alwaysOnEn}, 8'h00);
            end
            pins(1'b1, 1'b1);
            cyc(15 * MSC);
            check({7'h00, resetWire}, 8'h00);
            waitSig(0, 1'b1, 400, n);
            waitState(PS_ON, 50);
            check({7'h00, irqWire}, 8'h00);
            rdReg(ADDR_STATUS);
            check(rd, flagExp[k]);
            cyc(3);
            check({7'h00, irqWire}, 8'h01);
            rdReg(ADDR_STATUS);
            check(rd, 8'h00);
            if (k == 0) begin
                cyc(1000 * MSC);
                wr(ADDR_CONTROL, 8'h04);
                wr(ADDR_CONTROL, 8'h00);
            end
        end
        // sleep, woken by enable then by the button
        enReq <= 1'b0;
        waitState(PS_SLEEP, 20);
        check({6'h00, coreEn, mainEn}, 8'h01);
        enReq <= 1'b1;
        waitState(PS_ON, 20);
        enReq <= 1'b0;
        waitState(PS_SLEEP, 20);
        pins(1'b0, 1'b1);
        waitSig(1, 1'b1, 20, n);
        enReq <= 1'b1;
        pins(1'b1, 1'b1);
        waitState(PS_ON, 20);
        // shutdown bit without arming is ignored
        wr(ADDR_CONTROL, 8'h02);
        cyc(5);
        rdReg(ADDR_STATE);
        check({5'h00, rd[2:0]}, {5'h00, PS_ON});
        wr(ADDR_CONTROL, 8'h01);
        wr(ADDR_CONTROL, 8'h02);
        waitState(PS_OFF, 20);
        // slow host, then hold dropped
        powerOn(8'h3C, 90);
        holdReq <= 1'b0;
        waitState(PS_OFF, 20);
        // forced shutdown with a long weak press
        powerOn(8'h0A, 50);
        pins(1'b0, 1'b1);
        cyc(9900 * MSC);
        rdReg(ADDR_STATE);
        check({5'h00, rd[2:0]}, {5'h00, PS_ON});
        waitState(PS_OFF, 200);
        holdReq <= 1'b0;
        pins(1'b1, 1'b1);
        waitState(PS_OFF, 50);
        check({5'h00, coreEn, mainEn, alwaysOnEn}, 8'h01);
        @(posedge mclk);
        batteryOk <= 1'b0;
        cyc(6);
        check({5'h00, coreEn, mainEn, alwaysOnEn}, 8'h00);
        check({5'h00, system_reset_out_n, button_state_out_n, interrupt_out_n}, 8'h00);
        check({7'h00, irqWire}, 8'h01);
        wr(ADDR_MASK, 8'h04);
        cyc(3);
        check({7'h00, irqWire}, 8'h00);
        stop_test();
    end
endmodule // pbrpc_top_tb
